// >>> oss_pkg.sv
package oss_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned STEP_UNIT_NS = 100000;
  localparam int unsigned TICK_CYCLES = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ****************************************************************
  // Limits, in step-time units and tenths of a volt
  // ****************************************************************
  localparam logic [23:0] STEP_TIME_MIN = 24'h000001;
  localparam logic [23:0] STEP_TIME_MAX = 24'h98967F;
  localparam logic signed [12:0] DC_LIM_LOW = 13'sh07D0;
  localparam logic signed [12:0] DC_LIM_HIGH = 13'sh0FA0;
  localparam logic [13:0] AC_RMS_LIM_LOW = 14'h0578;
  localparam logic [13:0] AC_RMS_LIM_HIGH = 14'h0AF0;
  localparam logic [13:0] AC_PP_LIM_LOW = 14'h0FA0;
  localparam logic [13:0] AC_PP_LIM_HIGH = 14'h1F40;
  localparam logic [9:0] JUMP_COUNT_MAX = 10'h3E7;
  localparam logic [7:0] STEP_FIRST = 8'h01;
  localparam logic [7:0] STEP_LAST = 8'hFF;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_STEP_SEL = 8'h0C;
  localparam logic [7:0] ADDR_STEP_TIME = 8'h10;
  localparam logic [7:0] ADDR_STEP_DC = 8'h14;
  localparam logic [7:0] ADDR_STEP_AC = 8'h18;
  localparam logic [7:0] ADDR_STEP_FLOW = 8'h1C;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CFG_RANGE_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_STEP_LSB = 8;
  localparam int ST_CODE_LSB = 16;
  localparam int ST_OUT_ON_BIT = 20;
  localparam int VAL_LSB = 0;
  localparam int OP_LSB = 16;
  localparam int AC_PP_BIT = 20;
  localparam int AC_ARB_BIT = 21;
  localparam int FL_CODE_LSB = 0;
  localparam int FL_PHASE_BIT = 4;
  localparam int FL_TARGET_LSB = 8;
  localparam int FL_COUNT_LSB = 16;

  localparam logic [1:0] OP_CONST = 2'h0;
  localparam logic [1:0] OP_KEEP = 2'h1;
  localparam logic [1:0] OP_SWEEP = 2'h2;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_RUN = 2'h1;
  localparam logic [1:0] MODE_HOLD = 2'h2;
  localparam logic [1:0] MODE_PHASE_WAIT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PHASE_WAIT, ST_HOLD} oss_state_t;

  typedef struct packed {
    logic [23:0] dur;
    logic signed [12:0] dc_value;
    logic [1:0] dc_op;
    logic [13:0] ac_value;
    logic [1:0] ac_op;
    logic ac_pp;
    logic ac_arb;
    logic [1:0] code;
    logic phase_en;
    logic [7:0] jump_target;
    logic [9:0] jump_count;
  } oss_step_t;

  typedef struct packed {
    logic signed [12:0] dc;
    logic [13:0] ac;
    logic ac_pp;
  } oss_target_t;

endpackage

// >>> oss_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module oss_sequencer (
  input wire logic ref_clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic output_on, // Output stage switched on.
  input wire logic internal_ac_output_mode, // Internal AC mode selected.
  input wire logic internal_ac_dc_output_mode, // Internal AC+DC mode selected.
  input wire logic ac_phase_zero, // Pulse when AC phase crosses zero.
  output var oss_pkg::oss_target_t target_out, // Voltage targets.
  output logic step_code_bit0_out, // Step code bit 0.
  output logic step_code_bit1_out, // Step code bit 1.
  output logic seq_active_out // Sequence not idle.
);
  import oss_pkg::*;

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  oss_step_t step_mem [0:255];
  logic [9:0] jump_cnt [0:255];
  oss_state_t state_reg;
  logic [7:0] cur_step_reg;
  logic [7:0] sel_reg;
  logic range_high_reg;
  logic [23:0] elapsed_reg;
  logic [TICK_W-1:0] tick_reg;
  logic signed [15:0] prev_dc_reg;
  logic signed [15:0] prev_ac_reg;
  oss_target_t target_reg;
  logic [1:0] code_reg;
  logic active_reg;
  logic awready_reg;
  logic wready_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  oss_step_t cur;
  logic time_done;
  logic take_jump;
  logic [7:0] nxt_step;
  logic seq_end;
  logic advance;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic cmd_start;
  logic cmd_hold;
  logic cmd_stop;
  logic prog_ok;
  logic signed [12:0] dc_lim;
  logic [13:0] ac_lim;
  logic signed [15:0] dc_live;
  logic signed [15:0] ac_live;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic signed [15:0] sweep_val(input logic signed [15:0] from,
                                                   input logic signed [15:0] to,
                                                   input logic [23:0] el,
                                                   input logic [23:0] dur);
    logic signed [16:0] diff;
    logic signed [41:0] prod;
    logic signed [41:0] quot;
    diff = 17'(to) - 17'(from);
    prod = 42'(diff) * $signed({18'h00000, el});
    quot = (dur == 24'h000000) ? 42'(diff) : prod / $signed({18'h00000, dur});
    return 16'(from + 16'(quot));
  endfunction

  function automatic logic signed [15:0] op_val(input logic [1:0] op,
                                                input logic signed [15:0] prog,
                                                input logic signed [15:0] prev,
                                                input logic [23:0] el,
                                                input logic [23:0] dur);
    logic signed [15:0] v;
    v = prog;
    if (op == OP_KEEP) begin
      v = prev;
    end else if (op == OP_SWEEP) begin
      v = sweep_val(prev, prog, el, dur);
    end
    return v;
  endfunction

  function automatic logic [1:0] mode_code(input oss_state_t s);
    logic [1:0] m;
    unique case (s)
      ST_IDLE: m = MODE_IDLE;
      ST_RUN: m = MODE_RUN;
      ST_HOLD: m = MODE_HOLD;
      ST_PHASE_WAIT: m = MODE_PHASE_WAIT;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] addr);
    logic [31:0] w;
    w = 32'h00000000;
    case (addr)
      ADDR_CFG: w[CFG_RANGE_BIT] = range_high_reg;
      ADDR_STATUS: begin
        w[ST_MODE_LSB +: 2] = mode_code(state_reg);
        w[ST_STEP_LSB +: 8] = cur_step_reg;
        w[ST_CODE_LSB +: 2] = code_reg;
        w[ST_OUT_ON_BIT] = output_on;
      end
      ADDR_STEP_SEL: w[7:0] = sel_reg;
      ADDR_STEP_TIME: w[23:0] = step_mem[sel_reg].dur;
      ADDR_STEP_DC: begin
        w[VAL_LSB +: 13] = step_mem[sel_reg].dc_value;
        w[OP_LSB +: 2] = step_mem[sel_reg].dc_op;
      end
      ADDR_STEP_AC: begin
        w[VAL_LSB +: 14] = step_mem[sel_reg].ac_value;
        w[OP_LSB +: 2] = step_mem[sel_reg].ac_op;
        w[AC_PP_BIT] = step_mem[sel_reg].ac_pp;
        w[AC_ARB_BIT] = step_mem[sel_reg].ac_arb;
      end
      ADDR_STEP_FLOW: begin
        w[FL_CODE_LSB +: 2] = step_mem[sel_reg].code;
        w[FL_PHASE_BIT] = step_mem[sel_reg].phase_en;
        w[FL_TARGET_LSB +: 8] = step_mem[sel_reg].jump_target;
        w[FL_COUNT_LSB +: 10] = step_mem[sel_reg].jump_count;
      end
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= ADDR_STEP_FLOW);
  endfunction

  // ****************************************************************
  // Write decode and checks
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{w_strb_reg[i]}};
    end
    wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wr_data = (rd_word(aw_addr_reg) & ~wr_mask) | (w_data_reg & wr_mask);
    prog_ok = internal_ac_output_mode || internal_ac_dc_output_mode;
    dc_lim = range_high_reg ? DC_LIM_HIGH : DC_LIM_LOW;
    if (wr_data[AC_PP_BIT]) begin
      ac_lim = range_high_reg ? AC_PP_LIM_HIGH : AC_PP_LIM_LOW;
    end else begin
      ac_lim = range_high_reg ? AC_RMS_LIM_HIGH : AC_RMS_LIM_LOW;
    end
    case (aw_addr_reg)
      ADDR_CTRL: wr_ok = output_on;
      ADDR_CFG: wr_ok = 1'b1;
      ADDR_STEP_SEL: wr_ok = wr_data[7:0] >= STEP_FIRST;
      ADDR_STEP_TIME: wr_ok = prog_ok && (wr_data[23:0] >= STEP_TIME_MIN) &&
                              (wr_data[23:0] <= STEP_TIME_MAX);
      ADDR_STEP_DC: wr_ok = internal_ac_dc_output_mode && (wr_data[OP_LSB +: 2] != 2'h3) &&
                            ($signed(wr_data[VAL_LSB +: 13]) <= dc_lim) &&
                            ($signed(wr_data[VAL_LSB +: 13]) >= -dc_lim);
      ADDR_STEP_AC: wr_ok = prog_ok && (wr_data[OP_LSB +: 2] != 2'h3) &&
                            (wr_data[VAL_LSB +: 14] <= ac_lim) &&
                            (!wr_data[AC_PP_BIT] || wr_data[AC_ARB_BIT]);
      ADDR_STEP_FLOW: wr_ok = prog_ok &&
                              (wr_data[FL_COUNT_LSB +: 10] <= JUMP_COUNT_MAX);
      default: wr_ok = 1'b0;
    endcase
    cmd_start = wr_fire && wr_ok && (aw_addr_reg == ADDR_CTRL) && wr_data[CTRL_START_BIT];
    cmd_hold = wr_fire && wr_ok && (aw_addr_reg == ADDR_CTRL) && wr_data[CTRL_HOLD_BIT];
    cmd_stop = wr_fire && wr_ok && (aw_addr_reg == ADDR_CTRL) && wr_data[CTRL_STOP_BIT];
  end

  // ****************************************************************
  // Bus channels
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word(s_axi_araddr);
      rresp_reg <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Configuration and step memory
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      range_high_reg <= 1'b0;
      sel_reg <= STEP_FIRST;
      for (int i = 0; i < 256; i++) begin
        step_mem[i] <= '0;
      end
    end else if (wr_fire && wr_ok) begin
      case (aw_addr_reg)
        ADDR_CFG: range_high_reg <= wr_data[CFG_RANGE_BIT];
        ADDR_STEP_SEL: sel_reg <= wr_data[7:0];
        ADDR_STEP_TIME: step_mem[sel_reg].dur <= wr_data[23:0];
        ADDR_STEP_DC: begin
          step_mem[sel_reg].dc_value <= $signed(wr_data[VAL_LSB +: 13]);
          step_mem[sel_reg].dc_op <= wr_data[OP_LSB +: 2];
        end
        ADDR_STEP_AC: begin
          step_mem[sel_reg].ac_value <= wr_data[VAL_LSB +: 14];
          step_mem[sel_reg].ac_op <= wr_data[OP_LSB +: 2];
          step_mem[sel_reg].ac_pp <= wr_data[AC_PP_BIT];
          step_mem[sel_reg].ac_arb <= wr_data[AC_ARB_BIT];
        end
        ADDR_STEP_FLOW: begin
          step_mem[sel_reg].code <= wr_data[FL_CODE_LSB +: 2];
          step_mem[sel_reg].phase_en <= wr_data[FL_PHASE_BIT];
          step_mem[sel_reg].jump_target <= wr_data[FL_TARGET_LSB +: 8];
          step_mem[sel_reg].jump_count <= wr_data[FL_COUNT_LSB +: 10];
        end
        default: range_high_reg <= range_high_reg;
      endcase
    end
  end

  // ****************************************************************
  // Step transition
  // ****************************************************************
  always_comb begin
    cur = step_mem[cur_step_reg];
    time_done = elapsed_reg >= cur.dur;
    take_jump = (cur.jump_target != 8'h00) && ((cur.jump_count == 10'h000) ||
                (jump_cnt[cur_step_reg] != cur.jump_count));
    nxt_step = take_jump ? cur.jump_target : 8'(cur_step_reg + 8'h01);
    seq_end = (!take_jump && (cur_step_reg == STEP_LAST)) ||
              (step_mem[nxt_step].dur == 24'h000000);
    advance = !cmd_stop && !cmd_hold &&
              (((state_reg == ST_RUN) && time_done && !cur.phase_en) ||
               ((state_reg == ST_PHASE_WAIT) && ac_phase_zero));
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cur_step_reg <= STEP_FIRST;
      elapsed_reg <= 24'h000000;
      tick_reg <= '0;
      prev_dc_reg <= 16'sh0000;
      prev_ac_reg <= 16'sh0000;
    end else if (cmd_stop) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_start && (step_mem[STEP_FIRST].dur != 24'h000000)) begin
            state_reg <= ST_RUN;
            cur_step_reg <= STEP_FIRST;
            elapsed_reg <= 24'h000000;
            tick_reg <= '0;
            prev_dc_reg <= 16'(target_reg.dc);
            prev_ac_reg <= $signed({2'h0, target_reg.ac});
          end
        end
        ST_RUN: begin
          if (cmd_hold) begin
            state_reg <= ST_HOLD;
          end else if (time_done) begin
            if (cur.phase_en) begin
              state_reg <= ST_PHASE_WAIT;
            end
          end else if (tick_reg == TICK_LAST) begin
            tick_reg <= '0;
            elapsed_reg <= elapsed_reg + 24'h000001;
          end else begin
            tick_reg <= tick_reg + 1'b1;
          end
        end
        ST_PHASE_WAIT: begin
          if (cmd_hold) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cmd_start) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
      if (advance) begin
        if (seq_end) begin
          state_reg <= ST_IDLE;
        end else begin
          state_reg <= ST_RUN;
          cur_step_reg <= nxt_step;
          elapsed_reg <= 24'h000000;
          tick_reg <= '0;
          prev_dc_reg <= 16'(target_reg.dc);
          prev_ac_reg <= $signed({2'h0, target_reg.ac});
        end
      end
    end
  end

  // Counters survive other steps' activity, so nested loops are independent.
  always_ff @(posedge ref_clk) begin
    if (srst || (cmd_start && (state_reg == ST_IDLE))) begin
      for (int i = 0; i < 256; i++) begin
        jump_cnt[i] <= 10'h000;
      end
    end else if (advance && (cur.jump_target != 8'h00) && (cur.jump_count != 10'h000)) begin
      if (take_jump) begin
        jump_cnt[cur_step_reg] <= jump_cnt[cur_step_reg] + 10'h001;
      end else begin
        jump_cnt[cur_step_reg] <= 10'h000;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    dc_live = op_val(cur.dc_op, 16'(cur.dc_value), prev_dc_reg, elapsed_reg, cur.dur);
    ac_live = op_val(cur.ac_op, $signed({2'h0, cur.ac_value}), prev_ac_reg,
                     elapsed_reg, cur.dur);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      target_reg <= '0;
      code_reg <= 2'h0;
      active_reg <= 1'b0;
    end else begin
      active_reg <= state_reg != ST_IDLE;
      if ((state_reg == ST_RUN) || (state_reg == ST_PHASE_WAIT)) begin
        target_reg.dc <= internal_ac_dc_output_mode ? 13'(dc_live) : 13'sh0000;
        target_reg.ac <= 14'(ac_live);
        target_reg.ac_pp <= cur.ac_pp;
      end
      code_reg <= (state_reg == ST_IDLE) ? 2'h0 : cur.code;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign target_out = target_reg;
  assign step_code_bit0_out = code_reg[0];
  assign step_code_bit1_out = code_reg[1];
  assign seq_active_out = active_reg;

endmodule

`default_nettype wire

// >>> oss_sequencer_asserts.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Port checks of the step sequencer
// ****************************************************************
module oss_sequencer_asserts
  import oss_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic [7:0] s_axi_awaddr, // Address.
  input wire logic s_axi_awvalid, // Valid.
  input wire logic s_axi_awready, // Ready.
  input wire logic [1:0] s_axi_bresp, // Response.
  input wire logic s_axi_bvalid, // Valid.
  input wire logic s_axi_bready, // Ready.
  input wire logic s_axi_arvalid, // Valid.
  input wire logic s_axi_arready, // Ready.
  input wire logic [31:0] s_axi_rdata, // Data.
  input wire logic [1:0] s_axi_rresp, // Response.
  input wire logic s_axi_rvalid, // Valid.
  input wire logic s_axi_rready, // Ready.
  input wire logic output_on, // Output on.
  input wire logic ac_phase_zero, // Phase zero.
  input wire logic step_code_bit0_out, // Code bit 0.
  input wire logic step_code_bit1_out, // Code bit 1.
  input wire logic seq_active_out // Active.
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  AST_IDLE_ZERO: assert property (
    !seq_active_out |-> !step_code_bit0_out && !step_code_bit1_out)
    else $error("code not zero in idle");
  AST_OFF_IDLE: assert property (
    !output_on && !seq_active_out |=> !seq_active_out)
    else $error("sequence started with output off");
  AST_CTRL_OFF: assert property (
    !output_on && s_axi_awvalid && s_axi_awready && s_axi_awaddr == ADDR_CTRL
    |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("control write accepted with output off");
  AST_CODE_STEADY: assert property (
    seq_active_out && $changed({step_code_bit1_out, step_code_bit0_out})
    |=> (!seq_active_out || $stable({step_code_bit1_out, step_code_bit0_out}))[*8])
    else $error("step code changed within a step");
  AST_BRESP_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RDATA_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_ERR_ZERO: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  AST_RESET_READY: assert property (
    $fell(srst) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus not idle after reset");

  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property ($rose(seq_active_out));
  cover property (seq_active_out && ac_phase_zero);
endmodule

`default_nettype wire

// >>> output_step_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Self-checking bench of the step sequencer
// ****************************************************************
module output_step_sequencer_tb;
  import oss_pkg::*;
  localparam logic [33:0] W_OK = {RESP_OKAY, 32'h0};
  logic ref_clk = 1'b0, srst = 1'b1, output_on = 1'b0, ac_phase_zero = 1'b0;
  logic internal_ac_output_mode = 1'b1, internal_ac_dc_output_mode = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ca, cb, code_prev = 2'h0;
  logic [31:0] s_axi_rdata;
  logic step_code_bit0_out, step_code_bit1_out, seq_active_out, phase_done = 1'b0;
  oss_target_t target_out;
  logic [33:0] rq[$], cq[$];
  int failures = 0, compares = 0, i;
  logic [41:0] tbl[10] = '{
    {ADDR_CTRL, 32'h00000001, RESP_SLVERR},
    {ADDR_STEP_SEL, 32'h00000000, RESP_SLVERR},
    {ADDR_STEP_DC, 32'h00000000, RESP_SLVERR},
    {ADDR_STEP_AC, 32'h0010000A, RESP_SLVERR},
    {ADDR_STEP_AC, 32'h00000579, RESP_SLVERR},
    {ADDR_STEP_AC, 32'h00300FA1, RESP_SLVERR},
    {ADDR_STEP_AC, 32'h00000578, RESP_OKAY},
    {ADDR_STEP_TIME, 32'h00000000, RESP_SLVERR},
    {ADDR_STEP_TIME, 32'h0098967F, RESP_OKAY},
    {ADDR_STEP_FLOW, 32'h03E80000, RESP_SLVERR}};

  oss_sequencer u_oss_sequencer (.*);

  always #50 ref_clk = ~ref_clk;

  task automatic stop_test();
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic timeout();
    failures++;
    stop_test();
  endtask

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [33:0] pop(ref logic [33:0] q[$]);
    return q.size() ? q.pop_front() : 'x;
  endfunction

  // One AXI4-Lite transfer; the expected answer goes on the queue first.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] e);
    int n;
    rq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n == 100) timeout();
    // Lets an edge pass so the next call never reassigns a released strobe.
    @(posedge ref_clk);
  endtask

  task automatic prog(input logic [7:0] n, input logic [31:0] f);
    xfer(1'b1, ADDR_STEP_SEL, {24'h0, n}, W_OK);
    xfer(1'b1, ADDR_STEP_TIME, 32'h1, W_OK);
    xfer(1'b1, ADDR_STEP_FLOW, f, W_OK);
  endtask

  task automatic wait_cq(input int n, input int lim);
    int k;
    for (k = 0; k < lim && cq.size() > n; k++) @(posedge ref_clk);
    if (cq.size() > n) timeout();
  endtask

  always @(posedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {s_axi_bresp, 32'h0}, pop(rq));
    if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, pop(rq));
    if (!srst && {step_code_bit1_out, step_code_bit0_out} !== code_prev) begin
      chk("code", {16'h0, seq_active_out, target_out.ac, phase_done, step_code_bit1_out,
                   step_code_bit0_out}, pop(cq));
    end
    code_prev = {step_code_bit1_out, step_code_bit0_out};
  end

  initial begin
    void'($urandom(31));
    ca = 2'(1 + $urandom % 3);
    cb = 2'(ca % 3 + 1);
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 10; i++) xfer(1'b1, tbl[i][41:34], tbl[i][33:2], {tbl[i][1:0], 32'h0});
    xfer(1'b0, 8'h24, 32'h0, {RESP_SLVERR, 32'h0});
    output_on <= 1'b1;
    prog(8'h01, {30'h0, ca});
    prog(8'h02, {30'h0000_8040, cb});
    prog(8'h03, {30'h0000_0004, ca});
    xfer(1'b1, ADDR_STEP_AC, 32'h00020100, W_OK);
    for (i = 0; i < 7; i++) begin
      cq.push_back({16'h0, 1'b1, (i[0] || i == 6) ? 14'h0 : 14'h578, 1'b0,
                    i[0] ? cb : ca});
    end
    cq.push_back({16'h0, 1'b0, 14'h100, 1'b1, 2'h0});
    xfer(1'b1, ADDR_CTRL, 32'h1, W_OK);
    wait_cq(1, 9000);
    repeat (1500) @(posedge ref_clk);
    phase_done = 1'b1;
    ac_phase_zero <= 1'b1;
    @(posedge ref_clk);
    ac_phase_zero <= 1'b0;
    wait_cq(0, 100);
    internal_ac_dc_output_mode <= 1'b1;
    xfer(1'b1, ADDR_STEP_DC, 32'h000007D1, {RESP_SLVERR, 32'h0});
    xfer(1'b1, ADDR_STEP_DC, 32'h00021830, W_OK);
    xfer(1'b0, ADDR_STEP_DC, 32'h0, {RESP_OKAY, 32'h00021830});
    repeat (2) @(posedge ref_clk);
    chk("pending", 34'(rq.size()), 34'h0);
    stop_test();
  end
endmodule

bind oss_sequencer oss_sequencer_asserts u_oss_sequencer_asserts (.*);

`default_nettype wire
